// ### src/radio_cmd_core_handler.sv
`timescale 1ns/1ps
// Overview of operation
// - revision query replies status then eight identity bytes in fixed order
// - opcode 0x11 takes no arguments, replies status only, enters powerdown
// - in powerdown only power-up is accepted; others get no reply at all
// - clear-to-send set after each command; host waits for it before next
// - opcode 0x12 takes zero, id high, id low, value high, value low
// - property read replies zero, then value high, then value low
// - opcode 0x14 refreshes status bits 6:0 from current error and flags
// - status: bit7 ready, bit6 error, 3..0 quality, alert, audio, tune flags
// - opcode 0x01 boots the device, sole path from powerdown to powerup
module radio_cmd_core_handler
  import radio_cmd_pkg::*;
#(
  parameter int         EXEC_LEN          = EXEC_CYCLES,
  parameter logic [7:0] PART_DIGITS       = 8'h00, // arbitrary
  parameter logic [7:0] FIRMWARE_MAJOR    = 8'h31, // arbitrary
  parameter logic [7:0] FIRMWARE_MINOR    = 8'h30, // arbitrary
  parameter logic [7:0] PATCH_ID_HIGH     = 8'h00, // arbitrary
  parameter logic [7:0] PATCH_ID_LOW      = 8'h00, // arbitrary
  parameter logic [7:0] COMPONENT_MAJOR   = 8'h31, // arbitrary
  parameter logic [7:0] COMPONENT_MINOR   = 8'h30, // arbitrary
  parameter logic [7:0] SILICON_REVISION  = 8'h41  // arbitrary
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // command byte stream from the serial front end
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_data,
  // reply byte stream to the serial front end
  input  wire logic        rd_req,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  // event sources for the status flags
  input  wire logic        signal_quality_irq_flag,
  input  wire logic        alert_message_irq_flag,
  input  wire logic        audio_quality_irq_flag,
  input  wire logic        tune_complete_irq_flag,
  input  wire logic        error_event,
  // property store port
  output logic             prop_wr,
  output logic             prop_rd,
  output logic [15:0]      prop_id,
  output logic [15:0]      prop_wdata,
  input  wire logic [15:0] prop_rdata,
  // mode and pacing
  output logic             powered_up,
  output logic             boot_start,
  output logic             clear_to_send
);

  // the countdown is eight bits wide and needs at least one cycle
  if (EXEC_LEN < 1 || EXEC_LEN > 255) begin : g_bad_exec_len
    $error("EXEC_LEN out of range");
  end

  localparam logic [7:0] EXEC_LOAD = 8'(EXEC_LEN - 1);

  cmd_state_t  state_q;
  logic [7:0]  opcode_q;
  logic [2:0]  arg_need_q;
  logic [2:0]  arg_idx_q;
  logic [7:0]  exec_cnt_q;
  logic [6:0]  stat_low_q;
  logic [7:0]  prop_hi_q;
  logic [7:0]  val_hi_q;
  logic [3:0]  resp_len_q;
  logic [3:0]  resp_idx_q;
  logic        reply_on_q;
  logic [2:0]  need_d;
  logic        known_d;
  logic        take_cmd;
  logic        exec_done;
  logic [7:0]  reply_byte;

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode

  always_comb begin
    known_d = 1'b1;
    case (wr_data)
      OP_POWER_UP:   need_d = ARGS_POWER_UP;
      OP_SET_PROP:   need_d = ARGS_SET_PROP;
      OP_GET_PROP:   need_d = ARGS_GET_PROP;
      OP_REVISION,
      OP_POWER_DOWN,
      OP_INT_STATUS: need_d = ARGS_NONE;
      default: begin
        need_d  = ARGS_NONE;
        known_d = 1'b0;
      end
    endcase
  end

  // powered down: only the power-up opcode is even looked at
  assign take_cmd = (state_q == ST_IDLE) && clear_to_send && wr_valid &&
                    (powered_up || wr_data == OP_POWER_UP);
  assign exec_done = (state_q == ST_EXEC) && (exec_cnt_q == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      opcode_q   <= 8'h00;
      arg_need_q <= 3'h0;
      arg_idx_q  <= 3'h0;
      exec_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take_cmd) begin
            opcode_q   <= known_d ? wr_data : 8'hff;
            arg_need_q <= need_d;
            arg_idx_q  <= 3'h1;
            exec_cnt_q <= EXEC_LOAD;
            state_q    <= (need_d == ARGS_NONE) ? ST_EXEC : ST_ARGS;
          end
        end
        ST_ARGS: begin
          if (wr_valid) begin
            arg_idx_q <= arg_idx_q + 3'h1;
            if (arg_idx_q == arg_need_q) state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (exec_cnt_q != 8'h00) exec_cnt_q <= exec_cnt_q - 8'h01;
          else state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // argument capture, high byte first
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prop_hi_q  <= 8'h00;
      val_hi_q   <= 8'h00;
      prop_id    <= 16'h0000;
      prop_wdata <= 16'h0000;
    end else if (state_q == ST_ARGS && wr_valid) begin
      case (arg_idx_q)
        ARG_PROP_HI: prop_hi_q  <= wr_data;
        ARG_PROP_LO: prop_id    <= {prop_hi_q, wr_data};
        ARG_VAL_HI:  val_hi_q   <= wr_data;
        ARG_VAL_LO:  prop_wdata <= {val_hi_q, wr_data};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution effects

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prop_wr    <= 1'b0;
      prop_rd    <= 1'b0;
      boot_start <= 1'b0;
      powered_up <= 1'b0;
    end else begin
      prop_wr    <= exec_done && opcode_q == OP_SET_PROP;
      prop_rd    <= (state_q == ST_ARGS) && wr_valid && opcode_q == OP_GET_PROP &&
                    arg_idx_q == arg_need_q;
      boot_start <= exec_done && opcode_q == OP_POWER_UP;
      if (exec_done && opcode_q == OP_POWER_UP) powered_up <= 1'b1;
      if (exec_done && opcode_q == OP_POWER_DOWN) powered_up <= 1'b0;
    end
  end

  // ready only once execution has finished
  always_ff @(posedge clk_sys) begin
    if (sys_rst) clear_to_send <= 1'b1;
    else if (take_cmd) clear_to_send <= 1'b0;
    else if (exec_done) clear_to_send <= 1'b1;
  end

  // status low bits are a snapshot, refreshed only by the refresh command;
  // error also latches for unknown opcodes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) stat_low_q <= 7'h00;
    else if (exec_done && opcode_q == OP_INT_STATUS) begin
      stat_low_q <= {error_event, 2'b00, signal_quality_irq_flag,
                     alert_message_irq_flag, audio_quality_irq_flag,
                     tune_complete_irq_flag};
    end else if (exec_done && opcode_q == 8'hff) begin
      stat_low_q[STAT_ERR_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply stream

  always_comb begin
    reply_byte = 8'h00;
    if (resp_idx_q == 4'h0) begin
      reply_byte = {clear_to_send, stat_low_q};
    end else if (opcode_q == OP_REVISION) begin
      case (resp_idx_q)
        4'h1:    reply_byte = PART_DIGITS;
        4'h2:    reply_byte = FIRMWARE_MAJOR;
        4'h3:    reply_byte = FIRMWARE_MINOR;
        4'h4:    reply_byte = PATCH_ID_HIGH;
        4'h5:    reply_byte = PATCH_ID_LOW;
        4'h6:    reply_byte = COMPONENT_MAJOR;
        4'h7:    reply_byte = COMPONENT_MINOR;
        4'h8:    reply_byte = SILICON_REVISION;
        default: reply_byte = 8'h00;
      endcase
    end else if (opcode_q == OP_GET_PROP) begin
      case (resp_idx_q)
        4'h2:    reply_byte = prop_rdata[15:8];
        4'h3:    reply_byte = prop_rdata[7:0];
        default: reply_byte = 8'h00;
      endcase
    end
  end

  // reply opens at each accepted command; rejected bytes never open one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reply_on_q <= 1'b0;
      resp_len_q <= RESP_NONE;
      resp_idx_q <= 4'h0;
      rd_valid   <= 1'b0;
      rd_data    <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      if (take_cmd) begin
        reply_on_q <= 1'b1;
        resp_idx_q <= 4'h0;
        resp_len_q <= (wr_data == OP_REVISION) ? RESP_REVISION :
                      (wr_data == OP_GET_PROP) ? RESP_GET_PROP : RESP_NONE;
      end else if (rd_req && reply_on_q) begin
        rd_valid <= 1'b1;
        rd_data  <= reply_byte;
        if (clear_to_send && resp_idx_q < resp_len_q) resp_idx_q <= resp_idx_q + 4'h1;
        else if (clear_to_send) reply_on_q <= 1'b0;
      end
    end
  end

endmodule // radio_cmd_core_handler

// ### common/radio_cmd_pkg.sv
package radio_cmd_pkg;

  // opcodes
  localparam logic [7:0] OP_POWER_UP   = 8'h01;
  localparam logic [7:0] OP_REVISION   = 8'h10;
  localparam logic [7:0] OP_POWER_DOWN = 8'h11;
  localparam logic [7:0] OP_SET_PROP   = 8'h12;
  localparam logic [7:0] OP_GET_PROP   = 8'h13;
  localparam logic [7:0] OP_INT_STATUS = 8'h14;

  // argument counts
  localparam logic [2:0] ARGS_POWER_UP = 3'h2;
  localparam logic [2:0] ARGS_SET_PROP = 3'h5;
  localparam logic [2:0] ARGS_GET_PROP = 3'h3;
  localparam logic [2:0] ARGS_NONE     = 3'h0;

  // response byte counts after status
  localparam logic [3:0] RESP_REVISION = 4'h8;
  localparam logic [3:0] RESP_GET_PROP = 4'h3;
  localparam logic [3:0] RESP_NONE     = 4'h0;

  // status byte fields
  localparam int STAT_CTS_BIT = 7;
  localparam int STAT_ERR_BIT = 6;

  // argument slot positions
  localparam logic [2:0] ARG_PROP_HI  = 3'h2;
  localparam logic [2:0] ARG_PROP_LO  = 3'h3;
  localparam logic [2:0] ARG_VAL_HI   = 3'h4;
  localparam logic [2:0] ARG_VAL_LO   = 3'h5;

  // processing latency between last argument and ready
  localparam int EXEC_CYCLES = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARGS = 3'b010,
    ST_EXEC = 3'b100
  } cmd_state_t;

endpackage

// ### tb/radio_cmd_core_handler_properties.sv
`timescale 1ns/1ps
module cmd_checker (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // host side
  input wire logic       wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic       rd_req,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  // device side
  input wire logic       prop_wr,
  input wire logic       prop_rd,
  input wire logic       powered_up,
  input wire logic       clear_to_send
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire take = wr_valid && clear_to_send;

  a_cts_drops: assert property (take && (powered_up || wr_data == 8'h01) |=> !clear_to_send)
    else $error("cts high after opcode");
  a_down_ignore: assert property (take && !powered_up && wr_data != 8'h01 |=> clear_to_send)
    else $error("opcode taken in powerdown");
  a_down_exec: assert property (take && powered_up && wr_data == 8'h11
    |=> !clear_to_send [*4] ##1 (clear_to_send && !powered_up)) else $error("power-down timing");
  a_up_done: assert property ($rose(powered_up) |-> $rose(clear_to_send))
    else $error("powerup without completion");
  a_read_cause: assert property (rd_valid |-> $past(rd_req))
    else $error("reply byte without read");
  a_busy_status: assert property (rd_valid && !$past(clear_to_send) |-> !rd_data[7])
    else $error("ready bit set while busy");
  a_prop_write: assert property (prop_wr |-> $rose(clear_to_send))
    else $error("property write pacing");
  a_prop_read: assert property (prop_rd |-> !clear_to_send)
    else $error("property read while idle");

  c_get: cover property (take && powered_up && wr_data == 8'h13);
  c_wr: cover property (prop_wr);
  c_down: cover property ($fell(powered_up));
endmodule // cmd_checker

bind radio_cmd_core_handler cmd_checker cmd_checker_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .rd_valid(rd_valid),
  .rd_data(rd_data), .prop_wr(prop_wr), .prop_rd(prop_rd), .powered_up(powered_up),
  .clear_to_send(clear_to_send));

// ### tb/prop_store_model.sv
`timescale 1ns/1ps
module prop_store_model (
  // property port of the core
  input  wire logic        clk_sys,
  input  wire logic        prop_wr,
  input  wire logic [15:0] prop_id,
  input  wire logic [15:0] prop_wdata,
  output logic      [15:0] prop_rdata
);
  logic [15:0] id_q  = '0;
  logic [15:0] val_q = '0;
  always_ff @(posedge clk_sys) begin
    if (prop_wr) begin
      id_q  <= prop_id;
      val_q <= prop_wdata;
    end
  end
  // other ids read inverted, so a swapped id byte cannot pass
  assign prop_rdata = (prop_id == id_q) ? val_q : ~val_q;
endmodule // prop_store_model

// ### tb/tb_radio_cmd_core_handler.sv
`timescale 1ns/1ps
module tb_radio_cmd_core_handler import radio_cmd_pkg::*; ;
  logic        clk_sys = 0, sys_rst = 1, wr_valid = 0, rd_req = 0, error_event = 0;
  logic [7:0]  wr_data = '0, rd_data;
  logic [3:0]  flags = '0;
  logic        rd_valid, prop_wr, prop_rd, powered_up, boot_start, clear_to_send;
  logic [15:0] prop_id, prop_wdata, prop_rdata;
  int          err_total = 0, n_checks = 0, cyc = 0;

  // component and silicon bytes keep their defaults
  radio_cmd_core_handler #(.PART_DIGITS(8'ha1), .FIRMWARE_MAJOR(8'ha2),
    .FIRMWARE_MINOR(8'ha3), .PATCH_ID_HIGH(8'ha4), .PATCH_ID_LOW(8'ha5))
  radio_cmd_core_handler_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_valid(wr_valid),
    .wr_data(wr_data), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .signal_quality_irq_flag(flags[3]), .alert_message_irq_flag(flags[2]),
    .audio_quality_irq_flag(flags[1]), .tune_complete_irq_flag(flags[0]),
    .error_event(error_event), .prop_wr(prop_wr), .prop_rd(prop_rd), .prop_id(prop_id),
    .prop_wdata(prop_wdata), .prop_rdata(prop_rdata), .powered_up(powered_up),
    .boot_start(boot_start), .clear_to_send(clear_to_send));
  prop_store_model prop_store_model_inst (.clk_sys(clk_sys), .prop_wr(prop_wr),
    .prop_id(prop_id), .prop_wdata(prop_wdata), .prop_rdata(prop_rdata));

  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      wr_data = b[i];
      wr_valid = 1;
      @(posedge clk_sys) #1;
    end
    wr_valid = 0;
    // idle edge so a following send never re-raises wr_valid in the same step
    @(posedge clk_sys) #1;
  endtask
  task automatic wait_cts;
    int n = 0;
    while (clear_to_send !== 1'b1 && n < 40) begin
      @(posedge clk_sys) #1;
      n++;
    end
    chk({7'h0, clear_to_send}, 8'h01);
  endtask
  // an idle cycle after each read keeps rd_req from rising in the same step
  task automatic rd(input logic [7:0] e, input logic [7:0] m = 8'hff);
    rd_req = 1;
    @(posedge clk_sys) #1;
    rd_req = 0;
    chk({7'h0, rd_valid}, 8'h01);
    chk(rd_data & m, e);
    @(posedge clk_sys) #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // the reply closes on its last byte, so a further read must stay unanswered
  task automatic rd_none;
    rd_req = 1;
    @(posedge clk_sys) #1;
    rd_req = 0;
    chk({7'h0, rd_valid}, 8'h00);
    @(posedge clk_sys) #1;
  endtask
  task automatic s_down_ignore;
    send('{OP_REVISION});
    chk({7'h0, clear_to_send}, 8'h01);
    rd_none;
  endtask
  task automatic s_power_up(input logic [7:0] st);
    send('{OP_POWER_UP, 8'h03, 8'h05});
    wait_cts;
    chk({7'h0, powered_up}, 8'h01);
    chk({7'h0, boot_start}, 8'h01);
    rd(st);
    rd_none;
  endtask
  task automatic s_rev;
    send('{OP_REVISION});
    wait_cts;
    rd(8'h80);
    for (int i = 0; i < 5; i++) rd(8'ha1 + 8'(i));
    rd(8'h31);
    rd(8'h30);
    rd(8'h41);
    rd_none;
  endtask
  task automatic s_props;
    send('{OP_SET_PROP, 8'h00, 8'h12, 8'h34, 8'hab, 8'hcd});
    wait_cts;
    chk(prop_id[15:8], 8'h12);
    chk(prop_id[7:0], 8'h34);
    chk(prop_wdata[15:8], 8'hab);
    chk(prop_wdata[7:0], 8'hcd);
    rd(8'h80);
    rd_none;
    send('{OP_GET_PROP, 8'h00, 8'h12, 8'h34});
    wait_cts;
    rd(8'h80);
    rd(8'h00);
    rd(8'hab);
    rd(8'hcd);
    rd_none;
  endtask
  // 0x20 is no opcode of this core: the error bit must latch
  task automatic s_unknown;
    send('{8'h20});
    wait_cts;
    rd(8'hc0);
    rd_none;
  endtask
  task automatic s_int;
    flags = 4'hb;
    error_event = 1;
    send('{OP_INT_STATUS});
    rd(8'h00, 8'h80);
    wait_cts;
    rd(8'hcb);
    rd_none;
    flags = 4'h0;
    error_event = 0;
  endtask
  task automatic s_down;
    send('{OP_POWER_DOWN});
    wait_cts;
    chk({7'h0, powered_up}, 8'h00);
    rd(8'hcb);
    rd_none;
    send('{OP_SET_PROP, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00});
    chk({7'h0, clear_to_send}, 8'h01);
    s_down_ignore;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 0;
    s_down_ignore;
    s_power_up(8'h80);
    s_rev;
    s_props;
    s_unknown;
    s_int;
    s_down;
    s_power_up(8'hcb);
    complete_run;
  end
endmodule // tb_radio_cmd_core_handler
